// ---- logic/cmb_pkg.sv ----
// What this block does
// - Buffer fields map bit for bit onto the stored message object fields.
// - Low identifier mask in bits 15:0, reset 0xffff; zero bit never blocks.
// - High mask bits 12:0 cover identifier 28:16; one bit joins the compare.
// - Direction match enable at bit 14, reset one; zero ignores direction.
// - Long flag match enable at bit 15, reset one; zero ignores the flag.
// - Identifier split: 15:0 in low word, 28:16 in high bits 12:0; reset zero.
// - Standard frames use only an 11-bit identifier from the arbitration fields.
// - Direction bit 13, reset receive; receive send request sends a remote frame.
// - Receive object stores an accepted incoming data frame.
// - Transmit object sends data; matching remote frame sets its send request.
// - Long identifier flag bit 14: zero 11-bit, one 29-bit identifier.
// - Object valid bit 15: zero makes the handler ignore the object.
// - Mask transfer bit moves mask and both match enables to or from the object.
package cmb_pkg;
  // ==========================================================================
  // Register map.
  localparam logic [31:0] FIRST_MASK_LOW = 32'h40050028;
  localparam logic [31:0] FIRST_MASK_HIGH = 32'h4005002c;
  localparam logic [31:0] FIRST_ARB_LOW = 32'h40050030;
  localparam logic [31:0] FIRST_ARB_HIGH = 32'h40050034;
  localparam logic [31:0] SECOND_MASK_LOW = 32'h40050088;
  localparam logic [31:0] SECOND_MASK_HIGH = 32'h4005008c;
  localparam logic [31:0] SECOND_ARB_LOW = 32'h40050090;
  localparam logic [31:0] SECOND_ARB_HIGH = 32'h40050094;
  // ==========================================================================
  // Reset values of the 16 implemented bits.
  localparam logic [15:0] MASK_LOW_RST = 16'hffff;
  localparam logic [15:0] MASK_HIGH_RST = 16'hefff;
  localparam logic [15:0] ARB_LOW_RST = 16'h0000;
  localparam logic [15:0] ARB_HIGH_RST = 16'h0000;
  // Writable bits of the high mask word; bit 13 is reserved and reads one.
  localparam logic [15:0] MASK_HIGH_WMASK = 16'hdfff;
  // ==========================================================================
  // Field positions.
  localparam int HIGH_ID_MSB = 12;
  localparam int DIR_BIT = 13;
  localparam int LONG_BIT = 14;
  localparam int VALID_BIT = 15;
  localparam int DIRECTION_MATCH_ENABLE_BIT = 14;
  localparam int MLONG_BIT = 15;
  localparam int STD_ID_LSB = 18;
  localparam int PORTS = 2;
endpackage : cmb_pkg

// ---- logic/cmb_msg_buffer.sv ----
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
module cmb_msg_buffer (
  input wire logic core_clk,
  input wire logic reset,
  // Register port.
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  // Transfer commands from the message handler.
  input wire logic xferStb,
  input wire logic xferPort,
  input wire logic xferToObject,
  input wire logic xferMask,
  input wire logic xferArb,
  // Object fields presented by the message RAM on a read transfer.
  input wire logic [28:0] objMaskIn,
  input wire logic objMdirIn,
  input wire logic objMlongIn,
  input wire logic [28:0] objIdIn,
  input wire logic objDirIn,
  input wire logic objLongIn,
  input wire logic objValidIn,
  // Object fields driven back on a write transfer.
  output logic objWrStb,
  output logic objWrPort,
  output logic objWrMask,
  output logic objWrArb,
  output logic [31:0] objMaskOut,
  output logic [31:0] objArbOut,
  // Received frame for acceptance filtering.
  input wire logic rxStb,
  input wire logic [28:0] rxId,
  input wire logic rxLong,
  input wire logic rxRemote,
  input wire logic [1:0] remoteAnswerEnable,
  // Per-port filter and frame-kind results.
  output logic [1:0] acceptHit,
  output logic [1:0] storeData,
  output logic [1:0] setSendRequest,
  output logic [1:0] sendAsRemote,
  output logic [57:0] txIdent
);

  // ==========================================================================
  // Buffer register state.
  // Each port keeps only the 16 implemented bits of its four words, so bits
  // 31:16 can never be written and always read as zero.
  localparam int ID_W = 29; // Width of one port's slice of txIdent.
  logic [15:0] maskLow_ff [2];
  logic [15:0] maskHigh_ff [2];
  logic [15:0] arbLow_ff [2];
  logic [15:0] arbHigh_ff [2];

  // Register read path.
  logic [31:0] regRdData_ff;
  logic [31:0] nxt_regRdData;

  // Write transfer toward the message object.
  logic objWrStb_ff;
  logic objWrPort_ff;
  logic objWrMask_ff;
  logic objWrArb_ff;
  logic [31:0] objMaskOut_ff;
  logic [31:0] objArbOut_ff;
  logic nxt_objWrStb;
  logic nxt_objWrPort;
  logic nxt_objWrMask;
  logic nxt_objWrArb;
  logic [31:0] nxt_objMaskOut;
  logic [31:0] nxt_objArbOut;

  // Filter results and frame kind, one bit or one slice per port.
  logic [1:0] acceptHit_ff;
  logic [1:0] storeData_ff;
  logic [1:0] setSendRequest_ff;
  logic [1:0] sendAsRemote_ff;
  logic [57:0] txIdent_ff;

  // ==========================================================================
  // Per-port buffer, filter and frame kind.
  // One pass per access port; the two ports share the register bus, the transfer commands and the received frame.
  genvar p;
  generate
    for (p = 0; p < cmb_pkg::PORTS; p++) begin : gPort
      // Byte addresses of this port's four words.
      logic [31:0] baseMaskLow;
      logic [31:0] baseMaskHigh;
      logic [31:0] baseArbLow;
      logic [31:0] baseArbHigh;

      // Next values of the four buffer words.
      logic [15:0] nxt_maskLow;
      logic [15:0] nxt_maskHigh;
      logic [15:0] nxt_arbLow;
      logic [15:0] nxt_arbHigh;

      // Filter terms.
      logic [28:0] fullMask;
      logic [28:0] fullId;
      logic [28:0] cmpMask;
      logic [28:0] effId;
      logic dirOk;
      logic longOk;
      logic hit;

      // Next values of the registered results.
      logic nxt_accept;
      logic nxt_store;
      logic nxt_setSend;
      logic nxt_sendRemote;
      // Write selects and the read-transfer select of this port.
      logic wrMaskLow;
      logic wrMaskHigh;
      logic wrArbLow;
      logic wrArbHigh;
      logic xferHere;

      // Address decode of the four buffer words of this port.
      assign baseMaskLow = (p == 0) ? cmb_pkg::FIRST_MASK_LOW : cmb_pkg::SECOND_MASK_LOW;
      assign baseMaskHigh = (p == 0) ? cmb_pkg::FIRST_MASK_HIGH : cmb_pkg::SECOND_MASK_HIGH;
      assign baseArbLow = (p == 0) ? cmb_pkg::FIRST_ARB_LOW : cmb_pkg::SECOND_ARB_LOW;
      assign baseArbHigh = (p == 0) ? cmb_pkg::FIRST_ARB_HIGH : cmb_pkg::SECOND_ARB_HIGH;
      assign xferHere = xferStb && !xferToObject && (xferPort == 1'(p));

      // Software write strobes, one per word; other addresses select nothing.
      assign wrMaskLow = regWrStb && (regAddr == baseMaskLow);
      assign wrMaskHigh = regWrStb && (regAddr == baseMaskHigh);
      assign wrArbLow = regWrStb && (regAddr == baseArbLow);
      assign wrArbHigh = regWrStb && (regAddr == baseArbHigh);

      // Software writes land on the low 16 bits; a read transfer from the
      // object overrides a software write in the same cycle.
      always_comb begin
        nxt_maskLow = maskLow_ff[p];
        nxt_maskHigh = maskHigh_ff[p];
        nxt_arbLow = arbLow_ff[p];
        nxt_arbHigh = arbHigh_ff[p];
        if (wrMaskLow) begin
          nxt_maskLow = regWrData[15:0];
        end
        // Bit 13 of the high mask word is reserved and always holds one.
        if (wrMaskHigh) begin
          nxt_maskHigh = (regWrData[15:0] & cmb_pkg::MASK_HIGH_WMASK)
                         | ~cmb_pkg::MASK_HIGH_WMASK;
        end
        if (wrArbLow) begin
          nxt_arbLow = regWrData[15:0];
        end
        if (wrArbHigh) begin
          nxt_arbHigh = regWrData[15:0];
        end
        if (xferHere && xferMask) begin
          nxt_maskLow = objMaskIn[15:0];
          nxt_maskHigh = {objMlongIn, objMdirIn, 1'b1, objMaskIn[28:16]};
        end
        if (xferHere && xferArb) begin
          nxt_arbLow = objIdIn[15:0];
          // Valid, long flag and direction travel with the identifier.
          nxt_arbHigh = {objValidIn, objLongIn, objDirIn, objIdIn[28:16]};
        end
        // Frame kind follows the direction bit that the next edge will hold.
        nxt_sendRemote = !nxt_arbHigh[cmb_pkg::DIR_BIT];
      end

      // Acceptance filter: masked identifier compare plus direction and flag.
      always_comb begin
        fullMask = {maskHigh_ff[p][cmb_pkg::HIGH_ID_MSB:0], maskLow_ff[p]};
        fullId = {arbHigh_ff[p][cmb_pkg::HIGH_ID_MSB:0], arbLow_ff[p]};
        // Standard objects compare only identifier bits 28:18.
        cmpMask = fullMask;
        if (!arbHigh_ff[p][cmb_pkg::LONG_BIT]) begin
          cmpMask[cmb_pkg::STD_ID_LSB-1:0] = '0;
        end
        // A remote frame pairs with a transmit object, a data frame with a receive one.
        dirOk = !maskHigh_ff[p][cmb_pkg::DIRECTION_MATCH_ENABLE_BIT]
                || (rxRemote == arbHigh_ff[p][cmb_pkg::DIR_BIT]);
        longOk = !maskHigh_ff[p][cmb_pkg::MLONG_BIT]
                 || (rxLong == arbHigh_ff[p][cmb_pkg::LONG_BIT]);
        // An invalid object never matches, whatever its mask says.
        hit = rxStb && arbHigh_ff[p][cmb_pkg::VALID_BIT]
              && (((rxId ^ fullId) & cmpMask) == '0) && dirOk && longOk;
        nxt_accept = hit;
        // Store and answer pulses depend on the frame kind and the direction.
        nxt_store = hit && !arbHigh_ff[p][cmb_pkg::DIR_BIT] && !rxRemote;
        nxt_setSend = hit && arbHigh_ff[p][cmb_pkg::DIR_BIT] && rxRemote
                      && remoteAnswerEnable[p];
        // Identifier handed to the transmitter; standard frames keep bits 28:18.
        effId = fullId;
        if (!arbHigh_ff[p][cmb_pkg::LONG_BIT]) begin
          effId[cmb_pkg::STD_ID_LSB-1:0] = '0;
        end
      end

      // Reset leaves every object invalid, so no filter pulse can follow it.
      // Registers the buffer words and the per-port filter results.
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          maskLow_ff[p] <= cmb_pkg::MASK_LOW_RST;
          maskHigh_ff[p] <= cmb_pkg::MASK_HIGH_RST;
          arbLow_ff[p] <= cmb_pkg::ARB_LOW_RST;
          arbHigh_ff[p] <= cmb_pkg::ARB_HIGH_RST;
          acceptHit_ff[p] <= 1'b0;
          storeData_ff[p] <= 1'b0;
          setSendRequest_ff[p] <= 1'b0;
          sendAsRemote_ff[p] <= 1'b1;
          txIdent_ff[p*ID_W +: ID_W] <= '0;
        end else begin
          maskLow_ff[p] <= nxt_maskLow;
          maskHigh_ff[p] <= nxt_maskHigh;
          arbLow_ff[p] <= nxt_arbLow;
          arbHigh_ff[p] <= nxt_arbHigh;
          acceptHit_ff[p] <= nxt_accept;
          storeData_ff[p] <= nxt_store;
          setSendRequest_ff[p] <= nxt_setSend;
          sendAsRemote_ff[p] <= nxt_sendRemote;
          txIdent_ff[p*ID_W +: ID_W] <= effId;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read data mux; unmapped addresses and bits 31:16 read zero.
  // The read word stands until the next read, so a late sample still sees it.
  always_comb begin
    nxt_regRdData = regRdData_ff;
    if (regRdStb) begin
      nxt_regRdData = '0;
      // Only the low half is ever loaded; the upper half stays zero.
      case (regAddr)
        cmb_pkg::FIRST_MASK_LOW: nxt_regRdData[15:0] = maskLow_ff[0];
        cmb_pkg::FIRST_MASK_HIGH: nxt_regRdData[15:0] = maskHigh_ff[0];
        cmb_pkg::FIRST_ARB_LOW: nxt_regRdData[15:0] = arbLow_ff[0];
        cmb_pkg::FIRST_ARB_HIGH: nxt_regRdData[15:0] = arbHigh_ff[0];
        cmb_pkg::SECOND_MASK_LOW: nxt_regRdData[15:0] = maskLow_ff[1];
        cmb_pkg::SECOND_MASK_HIGH: nxt_regRdData[15:0] = maskHigh_ff[1];
        cmb_pkg::SECOND_ARB_LOW: nxt_regRdData[15:0] = arbLow_ff[1];
        cmb_pkg::SECOND_ARB_HIGH: nxt_regRdData[15:0] = arbHigh_ff[1];
        default: nxt_regRdData = '0;
      endcase
    end
  end

  // ==========================================================================
  // Write transfer toward the object: copies the selected buffer words.
  // Both words are copied every time; the group strobes tell the object
  // which of them to keep.
  always_comb begin
    nxt_objWrStb = xferStb && xferToObject;
    nxt_objWrPort = objWrPort_ff;
    nxt_objWrMask = nxt_objWrStb && xferMask;
    nxt_objWrArb = nxt_objWrStb && xferArb;
    nxt_objMaskOut = objMaskOut_ff;
    nxt_objArbOut = objArbOut_ff;
    if (nxt_objWrStb) begin
      nxt_objWrPort = xferPort;
      nxt_objMaskOut = {maskHigh_ff[xferPort], maskLow_ff[xferPort]};
      nxt_objArbOut = {arbHigh_ff[xferPort], arbLow_ff[xferPort]};
    end
  end

  // Reset clears every transfer output so no stray object write follows it.
  // Registers the read data and the write-transfer outputs.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdData_ff <= '0;
      objWrStb_ff <= 1'b0;
      objWrPort_ff <= 1'b0;
      objWrMask_ff <= 1'b0;
      objWrArb_ff <= 1'b0;
      objMaskOut_ff <= '0;
      objArbOut_ff <= '0;
    end else begin
      regRdData_ff <= nxt_regRdData;
      objWrStb_ff <= nxt_objWrStb;
      objWrPort_ff <= nxt_objWrPort;
      objWrMask_ff <= nxt_objWrMask;
      objWrArb_ff <= nxt_objWrArb;
      objMaskOut_ff <= nxt_objMaskOut;
      objArbOut_ff <= nxt_objArbOut;
    end
  end

  // ==========================================================================
  // Outputs come straight from their flip-flops.
  assign regRdData = regRdData_ff;

  // Write transfer toward the object.
  assign objWrStb = objWrStb_ff;
  assign objWrPort = objWrPort_ff;
  assign objWrMask = objWrMask_ff;
  assign objWrArb = objWrArb_ff;
  assign objMaskOut = objMaskOut_ff;
  assign objArbOut = objArbOut_ff;

  // Filter pulses and transmit settings.
  assign acceptHit = acceptHit_ff;
  assign storeData = storeData_ff;
  assign setSendRequest = setSendRequest_ff;
  assign sendAsRemote = sendAsRemote_ff;
  assign txIdent = txIdent_ff;

endmodule : cmb_msg_buffer

// ---- tb/cmb_msg_checker.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Port checker for the message buffer.
module cmb_msg_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic xferStb,
  input wire logic xferToObject,
  input wire logic xferMask,
  input wire logic xferArb,
  input wire logic objWrStb,
  input wire logic objWrMask,
  input wire logic objWrArb,
  input wire logic [31:0] objMaskOut,
  input wire logic rxStb,
  input wire logic rxRemote,
  input wire logic [1:0] remoteAnswerEnable,
  input wire logic [1:0] acceptHit,
  input wire logic [1:0] storeData,
  input wire logic [1:0] setSendRequest
);
  // All properties share the core clock and stop during reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Transfer strobes, register reads and filter pulses tied to their causes.
  a_wr_strobe: assert property (
    xferStb && xferToObject |=> objWrStb && objWrMask == $past(xferMask))
    else $error("write transfer strobe wrong");
  a_arb_strobe: assert property (
    xferStb && xferToObject |=> objWrArb == $past(xferArb))
    else $error("arbitration transfer strobe wrong");
  a_no_stray: assert property (
    !(xferStb && xferToObject) |=> !objWrStb) else $error("stray object write");
  a_mask_resv: assert property (
    objWrStb |-> objMaskOut[29]) else $error("reserved mask bit not one");
  a_hit_cause: assert property (
    acceptHit != 2'b00 |-> $past(rxStb)) else $error("hit without frame");
  a_store_kind: assert property (
    storeData[0] |-> acceptHit[0] && !$past(rxRemote)) else $error("bad store");
  a_answer_kind: assert property (
    setSendRequest[1] |-> acceptHit[1] && $past(rxRemote) && $past(remoteAnswerEnable[1]))
    else $error("bad remote answer");
  a_rd_upper: assert property (
    $past(regRdStb) |-> regRdData[31:16] == 16'h0000) else $error("upper bits set");
  a_rd_hold: assert property (
    !$past(regRdStb) |-> $stable(regRdData)) else $error("read data moved");
endmodule : cmb_msg_checker

// ---- tb/cmb_ram_model.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Message object store on the far side of the buffer.
module cmb_ram_model (
  input wire logic core_clk,
  input wire logic xferPort,
  input wire logic objWrStb,
  input wire logic objWrPort,
  input wire logic objWrMask,
  input wire logic objWrArb,
  input wire logic [31:0] objMaskOut,
  input wire logic [31:0] objArbOut,
  output logic [31:0] maskWord,
  output logic [31:0] arbWord
);
  logic [31:0] maskMem [2];
  logic [31:0] arbMem [2];
  // The selected object is shown with the same bit layout as the buffer.
  assign maskWord = maskMem[xferPort];
  assign arbWord = arbMem[xferPort];
  // Only the groups flagged in a write transfer are stored.
  always_ff @(posedge core_clk) begin
    if (objWrStb && objWrMask) maskMem[objWrPort] <= objMaskOut;
    if (objWrStb && objWrArb) arbMem[objWrPort] <= objArbOut;
  end
endmodule : cmb_ram_model

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
// ==========================================================================
// Bench for the message buffer.
module tb_top;
  logic core_clk = 0, reset = 1, regWrStb = 0, regRdStb = 0, xferStb = 0, xferPort = 0;
  logic xferToObject = 0, xferMask = 0, xferArb = 0, rxStb = 0, rxLong = 0, rxRemote = 0;
  logic objWrStb, objWrPort, objWrMask, objWrArb;
  logic [31:0] regAddr = 0, regWrData = 0, regRdData, objMaskOut, objArbOut, mw, aw;
  logic [28:0] rxId = 0, oid, msk;
  logic [1:0] rae = 0, acceptHit, storeData, setSendRequest, sendAsRemote;
  logic [57:0] txIdent;
  logic [31:0] ad [9];
  logic [31:0] om [2];
  logic [31:0] oa [2];
  logic [15:0] rg [9];
  int n_fail = 0, check_count = 0;
  // Clock and watchdog.
  initial forever #50 core_clk = ~core_clk;
  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
  cmb_msg_buffer i_cmb_msg_buffer (.core_clk(core_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .xferStb(xferStb), .xferPort(xferPort), .xferToObject(xferToObject),
    .xferMask(xferMask), .xferArb(xferArb), .objMaskIn(mw[28:0]), .objMdirIn(mw[30]),
    .objMlongIn(mw[31]), .objIdIn(aw[28:0]), .objDirIn(aw[29]), .objLongIn(aw[30]),
    .objValidIn(aw[31]), .objWrStb(objWrStb), .objWrPort(objWrPort), .objWrMask(objWrMask),
    .objWrArb(objWrArb), .objMaskOut(objMaskOut), .objArbOut(objArbOut), .rxStb(rxStb),
    .rxId(rxId), .rxLong(rxLong), .rxRemote(rxRemote), .remoteAnswerEnable(rae),
    .acceptHit(acceptHit), .storeData(storeData), .setSendRequest(setSendRequest),
    .sendAsRemote(sendAsRemote), .txIdent(txIdent));
  cmb_ram_model i_cmb_ram_model (.core_clk(core_clk), .xferPort(xferPort),
    .objWrStb(objWrStb), .objWrPort(objWrPort), .objWrMask(objWrMask), .objWrArb(objWrArb),
    .objMaskOut(objMaskOut), .objArbOut(objArbOut), .maskWord(mw), .arbWord(aw));
  // Register bus cycles; index 8 is an unmapped address.
  task automatic wr(int i, logic [31:0] d);
    @(posedge core_clk);
    regWrStb <= 1;
    regAddr <= ad[i];
    regWrData <= d;
    @(posedge core_clk);
    regWrStb <= 0;
    if (i < 8) rg[i] = (i % 4 == 1) ? (d[15:0] & 16'hdfff) | 16'h2000 : d[15:0];
  endtask : wr
  task automatic rd(int i);
    @(posedge core_clk);
    regRdStb <= 1;
    regAddr <= ad[i];
    @(posedge core_clk);
    regRdStb <= 0;
    #1 `CHK(regRdData, {16'h0000, rg[i]})
  endtask : rd
  // Transfer between buffer p and its object; write transfers are checked against the buffer copies.
  task automatic xf(int p, logic t, logic m, logic a);
    @(posedge core_clk);
    xferStb <= 1;
    xferPort <= p[0];
    xferToObject <= t;
    xferMask <= m;
    xferArb <= a;
    @(posedge core_clk);
    xferStb <= 0;
    #1;
    if (t) begin
      `CHK(objWrPort, p[0])
      if (m) `CHK(objMaskOut, {rg[4*p+1], rg[4*p]})
      if (a) `CHK(objArbOut, {rg[4*p+3], rg[4*p+2]})
      if (m) om[p] = {rg[4*p+1], rg[4*p]};
      if (a) oa[p] = {rg[4*p+3], rg[4*p+2]};
    end else begin
      if (m) {rg[4*p+1], rg[4*p]} = om[p];
      if (a) {rg[4*p+3], rg[4*p+2]} = oa[p];
    end
  endtask : xf
  // One received frame against the filter of both ports.
  task automatic rx(logic [28:0] id, logic lg, logic rm, logic [1:0] ae);
    logic [1:0] h, s, q;
    @(posedge core_clk);
    rxStb <= 1;
    rxId <= id;
    rxLong <= lg;
    rxRemote <= rm;
    rae <= ae;
    #1;
    for (int p = 0; p < 2; p++) begin
      oid = {rg[4*p+3][12:0], rg[4*p+2]};
      msk = {rg[4*p+1][12:0], rg[4*p]};
      if (!rg[4*p+3][14]) msk[17:0] = 18'h0;
      if (!rg[4*p+3][14]) oid[17:0] = 18'h0;
      `CHK(txIdent[29*p +: 29], oid)
      `CHK(sendAsRemote[p], ~rg[4*p+3][13])
      h[p] = rg[4*p+3][15] && ((id ^ oid) & msk) == 29'h0 && (!rg[4*p+1][14] ||
        rm == rg[4*p+3][13]) && (!rg[4*p+1][15] || lg == rg[4*p+3][14]);
      s[p] = h[p] && !rm && !rg[4*p+3][13];
      q[p] = h[p] && rm && rg[4*p+3][13] && ae[p];
    end
    @(posedge core_clk);
    rxStb <= 0;
    #1 `CHK(acceptHit, h)
    `CHK(storeData, s)
    `CHK(setSendRequest, q)
  endtask : rx
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // Main sequence: reset values, register access, transfers, filtering.
  initial begin
    void'($urandom(32'h7b28));
    ad = '{cmb_pkg::FIRST_MASK_LOW, cmb_pkg::FIRST_MASK_HIGH, cmb_pkg::FIRST_ARB_LOW,
      cmb_pkg::FIRST_ARB_HIGH, cmb_pkg::SECOND_MASK_LOW, cmb_pkg::SECOND_MASK_HIGH,
      cmb_pkg::SECOND_ARB_LOW, cmb_pkg::SECOND_ARB_HIGH, 32'h40050038};
    rg = '{16'hffff, 16'hefff, 16'h0, 16'h0, 16'hffff, 16'hefff, 16'h0, 16'h0, 16'h0};
    repeat (20) @(posedge core_clk);
    reset <= 0;
    for (int i = 0; i < 9; i++) rd(i);
    rx(29'h0, 1'b0, 1'b0, 2'($urandom));
    $display("test reset values done");
    repeat (3) begin
      for (int i = 0; i < 9; i++) wr(i, $urandom);
      for (int i = 0; i < 9; i++) rd(i);
    end
    $display("test register access done");
    for (int p = 0; p < 2; p++) xf(p, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) wr(i, $urandom);
    xf(0, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) wr(i, $urandom);
    xf(0, 1'b0, 1'b1, 1'b1);
    xf(1, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) rd(i);
    $display("test transfers done");
    for (int n = 0; n < 80; n++) begin
      if (n % 8 == 0) for (int i = 0; i < 8; i++) wr(i, $urandom);
      oid = {rg[3 + 4 * (n % 2)][12:0], rg[2 + 4 * (n % 2)]};
      msk = {rg[1 + 4 * (n % 2)][12:0], rg[4 * (n % 2)]};
      rx((n % 4 == 3) ? 29'($urandom) : oid ^ (29'($urandom) & ~msk), 1'($urandom),
        1'($urandom), 2'($urandom));
    end
    $display("test filtering done");
    final_report();
  end
endmodule : tb_top
bind cmb_msg_buffer cmb_msg_checker i_cmb_msg_checker (.core_clk(core_clk), .reset(reset),
  .regRdStb(regRdStb), .regRdData(regRdData), .xferStb(xferStb),
  .xferToObject(xferToObject), .xferMask(xferMask), .xferArb(xferArb), .objWrStb(objWrStb),
  .objWrMask(objWrMask), .objWrArb(objWrArb), .objMaskOut(objMaskOut), .rxStb(rxStb),
  .rxRemote(rxRemote),
  .remoteAnswerEnable(remoteAnswerEnable), .acceptHit(acceptHit), .storeData(storeData),
  .setSendRequest(setSendRequest));
